// file: hw/ipc_cfg.svh
// offsets, reset values, detection codes, limits and timing counts of the power path controller
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH

// register word indices on the plain register port
`define IPC_ADDR_CTRL 4'h0
`define IPC_ADDR_LIMIT_PIN 4'h1
`define IPC_ADDR_VLIM 4'h2
`define IPC_ADDR_VOFS 4'h3
`define IPC_ADDR_BSTV 4'h4
`define IPC_ADDR_BLIM 4'h5
`define IPC_ADDR_SMIN 4'h6
`define IPC_ADDR_STAT 4'h7
`define IPC_ADDR_OPTR 4'h8

// control register reset value: auto detect, optimizer, limit pin, charging enabled
`define IPC_CTRL_RST 10'h129

// field reset values
`define IPC_LIMIT_PIN_RST_MA 12'h1F4
`define IPC_VLIM_RST_MV 14'h1194
`define IPC_VOFS_RST_MV 13'h01F4
`define IPC_BSTV_RST_MV 13'h1388
`define IPC_BLIM_RST 3'h0
`define IPC_SMIN_RST_MV 13'h0DAC

// detection results and limits
`define IPC_LIMIT_PIN_SDP_MA 12'h1F4
`define IPC_LIMIT_PIN_DCP_MA 12'hCB2
`define IPC_LIMIT_PIN_SOFT_MA 12'h0C8
`define IPC_SRC_NONE 3'h0
`define IPC_SRC_SDP 3'h1
`define IPC_SRC_DCP 3'h2
`define IPC_SRC_OTG 3'h7
`define IPC_VLIM_MIN_MV 14'h0F3C
`define IPC_OPT_STEP_MA 12'h032

// timing
`define IPC_CLK_HZ 125000000
`define IPC_T_RETRY_MS 2000
`define IPC_T_BIAS_MS 220
`define IPC_T_BOOST_MS 30
`define IPC_RETRY_CYC (`IPC_T_RETRY_MS * (`IPC_CLK_HZ / 1000))
`define IPC_BIAS_CYC (`IPC_T_BIAS_MS * (`IPC_CLK_HZ / 1000))
`define IPC_BOOST_CYC (`IPC_T_BOOST_MS * (`IPC_CLK_HZ / 1000))
`define IPC_OPT_TICK_CYC 256

`endif

// file: hw/ipc_pkg.sv
// types of the power path controller
package ipc_pkg;

    typedef struct packed {
        logic vbus_uvlo_ok;
        logic vbus_above_sleepz;
        logic vbus_below_sleep;
        logic vbus_below_acov;
        logic vbus_above_min;
        logic psel;
        logic otg;
        logic bat_above_lowv;
        logic bat_above_otg;
        logic ts_boost_ok;
        logic sys_above_2v2;
        logic sys_below_bat;
        logic bat_above_depl;
        logic in_cur_over;
        logic in_volt_under;
        logic min_system_voltage_field_reg;
    } ipc_pins_s;

    typedef enum logic [2:0] {
        IPC_HIZ,
        IPC_QUAL,
        IPC_QWAIT,
        IPC_DETECT,
        IPC_VLIM,
        IPC_CONV,
        IPC_BOOST_WAIT,
        IPC_BOOST
    } ipc_state_e;

    typedef struct packed {
        logic hiz_en;
        logic chg_en;
        logic boost_frequency_select;
        logic bit_a;
        logic lim_pin_en;
        logic force_opt;
        logic opt_en;
        logic abs_sel;
        logic force_det;
        logic auto_det;
    } ipc_ctrl_s;

    typedef struct packed {
        ipc_pins_s sync1;
        ipc_pins_s sync2;
        ipc_pins_s sync3;
        ipc_pins_s filt;
        ipc_state_e st;
        logic [27:0] cnt;
        ipc_ctrl_s ctrl;
        logic [11:0] limit_pin_reg;
        logic [13:0] vlim;
        logic [12:0] vofs;
        logic [12:0] bstv;
        logic [2:0] blim;
        logic [12:0] smin;
        logic [2:0] src_stat;
        logic detection_speed_status;
        logic in_good;
        logic power_good_status;
        logic opt_run;
        logic [7:0] opt_cnt;
        logic [11:0] opt_res;
        logic opt_done;
        logic bias_en;
        logic conv_en;
        logic bat_sw;
        logic boost_en;
        logic boost_frequency_select_o;
        logic [11:0] eff_limit_pin;
        logic chg_reduce;
        logic vdpm;
        logic idpm;
        logic smin_stat;
        logic pg_b;
        logic int_b;
        logic [15:0] rd_data;
    } ipc_state_s;

endpackage : ipc_pkg

// file: hw/ipc_power_path.sv
// input power path control: qualification, source detection, limits, boost and power path
//
// The register addresses and the strobed register port were decided locally.
`include "ipc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ipc_power_path #(
    parameter int unsigned RETRY_CYC = `IPC_RETRY_CYC,
    parameter int unsigned BIAS_CYC = `IPC_BIAS_CYC,
    parameter int unsigned BOOST_CYC = `IPC_BOOST_CYC,
    parameter int unsigned OPT_TICK_CYC = `IPC_OPT_TICK_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire ipc_pkg::ipc_pins_s pins_in,
    input wire logic [11:0] limit_pin_ma_in,
    input wire logic [13:0] vbus_mv_in,
    output logic bias_en_out,
    output logic conv_en_out,
    output logic battery_switch_out,
    output logic boost_en_out,
    output logic boost_frequency_select_out,
    output logic [2:0] boost_current_limit_out,
    output logic [12:0] boost_voltage_out,
    output logic [12:0] min_system_voltage_out,
    output logic [13:0] input_voltage_limit_out,
    output logic [11:0] eff_limit_pin_out,
    output logic charge_reduce_out,
    output logic power_good_pin_b_out,
    output logic host_int_b_out
);
    import ipc_pkg::*;

    ipc_state_s s_r;
    ipc_state_s s_nxt;

    always_comb begin
        logic bias_ok;
        logic boost_ok;
        logic [11:0] lim;
        logic [14:0] vcalc;
        logic [15:0] rd;
        bias_ok = 1'b0;
        boost_ok = 1'b0;
        lim = 12'h000;
        vcalc = 15'h0000;
        rd = 16'h0000;
        s_nxt = s_r;

        // three stage input sampling, change accepted when stages two and three agree
        s_nxt.sync1 = pins_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        s_nxt.filt = (s_r.sync2 & ~(s_r.sync2 ^ s_r.sync3)) | (s_r.filt & (s_r.sync2 ^ s_r.sync3));

        s_nxt.int_b = 1'b1;
        bias_ok = s_r.filt.vbus_uvlo_ok && s_r.filt.vbus_above_sleepz && !s_r.ctrl.hiz_en;
        boost_ok = s_r.filt.otg && s_r.ctrl.bit_a && s_r.filt.bat_above_lowv
            && s_r.filt.vbus_below_sleep && s_r.filt.ts_boost_ok && s_r.filt.bat_above_otg;

        // power-up sequencer
        case (s_r.st)
            IPC_HIZ: begin
                s_nxt.bias_en = 1'b0;
                s_nxt.conv_en = 1'b0;
                s_nxt.boost_en = 1'b0;
                if (bias_ok) begin
                    s_nxt.cnt = s_r.cnt + 28'h0000001;
                    if (s_r.cnt >= 28'(BIAS_CYC - 1)) begin
                        s_nxt.cnt = 28'h0000000;
                        s_nxt.bias_en = 1'b1;
                        s_nxt.st = IPC_QUAL;
                    end
                end else if (boost_ok) begin
                    s_nxt.cnt = 28'h0000000;
                    s_nxt.st = IPC_BOOST_WAIT;
                end else begin
                    s_nxt.cnt = 28'h0000000;
                end
            end
            IPC_QUAL: begin
                if (s_r.filt.vbus_below_acov && s_r.filt.vbus_above_min) begin
                    s_nxt.in_good = 1'b1;
                    s_nxt.int_b = 1'b0;
                    s_nxt.st = IPC_DETECT;
                end else begin
                    s_nxt.cnt = 28'h0000000;
                    s_nxt.st = IPC_QWAIT;
                end
            end
            IPC_QWAIT: begin
                s_nxt.cnt = s_r.cnt + 28'h0000001;
                if (s_r.cnt >= 28'(RETRY_CYC - 1)) begin
                    s_nxt.cnt = 28'h0000000;
                    s_nxt.st = IPC_QUAL;
                end
            end
            IPC_DETECT: begin
                if (s_r.in_good && s_r.bias_en && (s_r.ctrl.auto_det || s_r.ctrl.force_det)) begin
                    if (s_r.filt.psel) begin
                        s_nxt.limit_pin_reg = `IPC_LIMIT_PIN_SDP_MA;
                        s_nxt.src_stat = `IPC_SRC_SDP;
                    end else begin
                        s_nxt.limit_pin_reg = `IPC_LIMIT_PIN_DCP_MA;
                        s_nxt.src_stat = `IPC_SRC_DCP;
                    end
                    s_nxt.detection_speed_status = 1'b1;
                    s_nxt.power_good_status = 1'b1;
                    s_nxt.pg_b = 1'b0;
                    s_nxt.int_b = 1'b0;
                    s_nxt.ctrl.force_det = 1'b0;
                end
                // with auto detect and force detect both off the previous results stay as they are
                s_nxt.st = IPC_VLIM;
            end
            IPC_VLIM: begin
                if (!s_r.ctrl.abs_sel) begin
                    vcalc = {1'b0, vbus_mv_in} - {2'b00, s_r.vofs};
                    if (vbus_mv_in < {1'b0, s_r.vofs} || vcalc[13:0] < `IPC_VLIM_MIN_MV) begin
                        s_nxt.vlim = `IPC_VLIM_MIN_MV;
                    end else begin
                        s_nxt.vlim = vcalc[13:0];
                    end
                end
                s_nxt.int_b = 1'b0;
                s_nxt.conv_en = 1'b1;
                s_nxt.opt_res = s_r.limit_pin_reg;
                if (s_r.ctrl.opt_en && s_r.src_stat == `IPC_SRC_DCP) begin
                    s_nxt.opt_run = 1'b1;
                    s_nxt.opt_cnt = 8'h00;
                end
                s_nxt.st = IPC_CONV;
            end
            IPC_CONV: begin
                s_nxt.conv_en = 1'b1;
                if (s_r.ctrl.force_det) begin
                    s_nxt.st = IPC_DETECT;
                end else if (s_r.ctrl.force_opt && !s_r.opt_run) begin
                    s_nxt.opt_run = 1'b1;
                    s_nxt.opt_cnt = 8'h00;
                    s_nxt.opt_res = s_r.limit_pin_reg;
                end
            end
            IPC_BOOST_WAIT: begin
                if (!boost_ok) begin
                    s_nxt.cnt = 28'h0000000;
                    s_nxt.st = IPC_HIZ;
                end else begin
                    s_nxt.cnt = s_r.cnt + 28'h0000001;
                    if (s_r.cnt >= 28'(BOOST_CYC - 1)) begin
                        s_nxt.cnt = 28'h0000000;
                        s_nxt.boost_en = 1'b1;
                        s_nxt.bias_en = 1'b1;
                        s_nxt.src_stat = `IPC_SRC_OTG;
                        s_nxt.st = IPC_BOOST;
                    end
                end
            end
            IPC_BOOST: begin
                if (!boost_ok) begin
                    s_nxt.boost_en = 1'b0;
                    s_nxt.bias_en = 1'b0;
                    s_nxt.src_stat = `IPC_SRC_NONE;
                    s_nxt.st = IPC_HIZ;
                end
            end
            default: begin
                s_nxt.st = IPC_HIZ;
            end
        endcase

        // loss of input conditions drops back to high impedance
        if (!bias_ok && s_r.st != IPC_HIZ && s_r.st != IPC_BOOST_WAIT && s_r.st != IPC_BOOST) begin
            s_nxt.st = IPC_HIZ;
            s_nxt.cnt = 28'h0000000;
            s_nxt.bias_en = 1'b0;
            s_nxt.conv_en = 1'b0;
            s_nxt.in_good = 1'b0;
            s_nxt.power_good_status = 1'b0;
            s_nxt.pg_b = 1'b1;
            s_nxt.opt_run = 1'b0;
        end

        // input current optimizer: steps down while the voltage limit is hit
        if (s_r.opt_run && s_r.st == IPC_CONV) begin
            s_nxt.opt_cnt = s_r.opt_cnt + 8'h01;
            if (32'(s_r.opt_cnt) >= OPT_TICK_CYC - 1) begin
                s_nxt.opt_cnt = 8'h00;
                if (s_r.filt.in_volt_under && s_r.opt_res > `IPC_OPT_STEP_MA) begin
                    s_nxt.opt_res = s_r.opt_res - `IPC_OPT_STEP_MA;
                end else begin
                    s_nxt.opt_run = 1'b0;
                    s_nxt.opt_done = 1'b1;
                    s_nxt.ctrl.force_opt = 1'b0;
                end
            end
        end

        // effective input current limit
        if (!s_r.filt.sys_above_2v2) begin
            lim = (s_r.limit_pin_reg < `IPC_LIMIT_PIN_SOFT_MA) ? s_r.limit_pin_reg : `IPC_LIMIT_PIN_SOFT_MA;
        end else begin
            lim = s_r.ctrl.opt_en ? s_r.opt_res : s_r.limit_pin_reg;
        end
        if (s_r.ctrl.lim_pin_en && limit_pin_ma_in < lim) begin
            lim = limit_pin_ma_in;
        end
        s_nxt.eff_limit_pin = lim;

        // dynamic power management and power path
        s_nxt.idpm = s_r.conv_en && s_r.filt.in_cur_over;
        s_nxt.vdpm = s_r.conv_en && s_r.filt.in_volt_under;
        s_nxt.chg_reduce = s_r.conv_en && (s_r.filt.in_cur_over || s_r.filt.in_volt_under);
        s_nxt.smin_stat = s_r.filt.min_system_voltage_field_reg;
        s_nxt.bat_sw = s_r.filt.bat_above_depl
            && (s_r.boost_en || !s_r.conv_en || s_r.ctrl.chg_en || s_r.filt.sys_below_bat);
        s_nxt.boost_frequency_select_o = s_r.ctrl.boost_frequency_select;

        // register writes; a host write lands after hardware clears, so a host set of force_det or force_opt is never lost
        if (reg_wr_in) begin
            case (reg_addr_in)
                `IPC_ADDR_CTRL: begin
                    s_nxt.ctrl = ipc_ctrl_s'(reg_wdata_in[9:0]);
                    if (s_r.ctrl.bit_a) begin
                        s_nxt.ctrl.boost_frequency_select = s_r.ctrl.boost_frequency_select;
                    end
                end
                `IPC_ADDR_LIMIT_PIN: s_nxt.limit_pin_reg = reg_wdata_in[11:0];
                `IPC_ADDR_VLIM: begin
                    if (s_r.ctrl.abs_sel) begin
                        s_nxt.vlim = reg_wdata_in[13:0];
                    end
                end
                `IPC_ADDR_VOFS: s_nxt.vofs = reg_wdata_in[12:0];
                `IPC_ADDR_BSTV: s_nxt.bstv = reg_wdata_in[12:0];
                `IPC_ADDR_BLIM: s_nxt.blim = reg_wdata_in[2:0];
                `IPC_ADDR_SMIN: s_nxt.smin = reg_wdata_in[12:0];
                default: begin
                end
            endcase
        end

        // register reads, data valid the cycle after the strobe only
        if (reg_rd_in) begin
            case (reg_addr_in)
                `IPC_ADDR_CTRL: rd = {6'h00, s_r.ctrl};
                `IPC_ADDR_LIMIT_PIN: rd = {4'h0, s_r.limit_pin_reg};
                `IPC_ADDR_VLIM: rd = {2'h0, s_r.vlim};
                `IPC_ADDR_VOFS: rd = {3'h0, s_r.vofs};
                `IPC_ADDR_BSTV: rd = {3'h0, s_r.bstv};
                `IPC_ADDR_BLIM: rd = {13'h0000, s_r.blim};
                `IPC_ADDR_SMIN: rd = {3'h0, s_r.smin};
                `IPC_ADDR_STAT: begin
                    rd = {3'h0, s_r.bias_en, s_r.boost_en, s_r.opt_done, s_r.smin_stat, s_r.idpm,
                          s_r.vdpm, s_r.power_good_status, s_r.in_good, s_r.detection_speed_status, 1'b0, s_r.src_stat};
                end
                `IPC_ADDR_OPTR: rd = {4'h0, s_r.opt_res};
                default: rd = 16'h0000;
            endcase
        end
        s_nxt.rd_data = rd;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '0;
            s_r.st <= IPC_HIZ;
            s_r.ctrl <= ipc_ctrl_s'(`IPC_CTRL_RST);
            s_r.limit_pin_reg <= `IPC_LIMIT_PIN_RST_MA;
            s_r.vlim <= `IPC_VLIM_RST_MV;
            s_r.vofs <= `IPC_VOFS_RST_MV;
            s_r.bstv <= `IPC_BSTV_RST_MV;
            s_r.blim <= `IPC_BLIM_RST;
            s_r.smin <= `IPC_SMIN_RST_MV;
            s_r.opt_res <= `IPC_LIMIT_PIN_RST_MA;
            s_r.pg_b <= 1'b1;
            s_r.int_b <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_out = s_r.rd_data;
    assign bias_en_out = s_r.bias_en;
    assign conv_en_out = s_r.conv_en;
    assign battery_switch_out = s_r.bat_sw;
    assign boost_en_out = s_r.boost_en;
    assign boost_frequency_select_out = s_r.boost_frequency_select_o;
    assign boost_current_limit_out = s_r.blim;
    assign boost_voltage_out = s_r.bstv;
    assign min_system_voltage_out = s_r.smin;
    assign input_voltage_limit_out = s_r.vlim;
    assign eff_limit_pin_out = s_r.eff_limit_pin;
    assign charge_reduce_out = s_r.chg_reduce;
    assign power_good_pin_b_out = s_r.pg_b;
    assign host_int_b_out = s_r.int_b;

endmodule : ipc_power_path

`default_nettype wire

// file: test/ipc_power_path_properties.sv
// port assertions of the power path controller
`timescale 1ns/1ns
`default_nettype none
module ipc_power_path_properties (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire ipc_pkg::ipc_pins_s pins_in,
    input wire logic bias_en_out,
    input wire logic conv_en_out,
    input wire logic battery_switch_out,
    input wire logic boost_en_out,
    input wire logic [11:0] eff_limit_pin_out,
    input wire logic charge_reduce_out,
    input wire logic power_good_pin_b_out,
    input wire logic host_int_b_out
);
    import ipc_pkg::*;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    a_conv_needs_bias: assert property (conv_en_out |-> bias_en_out)
        else $error("converter on without bias");
    a_pg_needs_bias: assert property (!power_good_pin_b_out |-> bias_en_out)
        else $error("power good low without bias");
    a_int_needs_bias: assert property (!host_int_b_out |-> bias_en_out)
        else $error("interrupt outside power-up");
    a_soft_start: assert property ((!pins_in.sys_above_2v2) [*6] |-> eff_limit_pin_out <= 12'h0C8)
        else $error("soft start limit above 200 mA");
    a_boost_alone: assert property (boost_en_out |-> !conv_en_out)
        else $error("boost and converter together");
    a_boost_cause: assert property ($rose(boost_en_out) |-> $past(pins_in.otg, 4) && $past(pins_in.bat_above_lowv, 4))
        else $error("boost without enable conditions");
    a_boost_drop: assert property ($fell(pins_in.bat_above_otg) |-> ##[1:6] !boost_en_out)
        else $error("boost kept on low battery");
    a_reduce_cur: assert property ((conv_en_out && pins_in.in_cur_over) [*6] |-> charge_reduce_out)
        else $error("no charge reduction on overcurrent");
    a_reduce_idle: assert property ((!pins_in.in_cur_over && !pins_in.in_volt_under) [*6] |-> !charge_reduce_out)
        else $error("charge reduced without overload");
    a_supp_depl: assert property ((!pins_in.bat_above_depl) [*6] |-> !battery_switch_out)
        else $error("battery switch on below depletion");
    a_bias_cause: assert property ($rose(bias_en_out) |-> boost_en_out || $past(pins_in.vbus_uvlo_ok, 6))
        else $error("bias up without input");
endmodule : ipc_power_path_properties
bind ipc_power_path ipc_power_path_properties i_ipc_power_path_properties (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pins_in(pins_in), .bias_en_out(bias_en_out),
    .conv_en_out(conv_en_out), .battery_switch_out(battery_switch_out), .boost_en_out(boost_en_out),
    .eff_limit_pin_out(eff_limit_pin_out), .charge_reduce_out(charge_reduce_out),
    .power_good_pin_b_out(power_good_pin_b_out), .host_int_b_out(host_int_b_out));
`default_nettype wire

// file: test/ipc_supply_model.sv
// input supply and source select model
`timescale 1ns/1ns
`default_nettype none
module ipc_supply_model (
    input wire logic sys_clk_in,
    input wire logic plug_in,
    input wire logic slow_in,
    input wire logic pass_in,
    input wire logic psel_in,
    input wire ipc_pkg::ipc_pins_s misc_in,
    output var ipc_pkg::ipc_pins_s pins_out,
    output var logic [13:0] vbus_mv_out
);
    import ipc_pkg::*;
    logic up = 1'b0;
    int ramp = 0;
    always @(posedge sys_clk_in) begin
        ramp = plug_in ? ramp + 1 : 0;
        up <= plug_in && (!slow_in || ramp > 12);
    end
    always_comb begin
        pins_out = misc_in;
        pins_out.vbus_uvlo_ok = up;
        pins_out.vbus_above_sleepz = up;
        pins_out.vbus_below_sleep = !up;
        pins_out.vbus_below_acov = up && pass_in;
        pins_out.vbus_above_min = up && pass_in;
        pins_out.psel = psel_in;
        vbus_mv_out = up ? 14'h1770 : 14'h0000;
    end
endmodule : ipc_supply_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench of the power path controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ipc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic plug = 1'b0;
    logic slow = 1'b1;
    logic pass = 1'b0;
    logic psel = 1'b1;
    logic [11:0] pin_ma = 12'hFFF;
    ipc_pins_s misc = 16'h0008;
    ipc_pins_s pins;
    logic [13:0] vbus_mv, vlim;
    logic [15:0] rdata, d;
    logic bias, conv, bsw, boost, bfreq, reduce, pg_b, int_b;
    logic [2:0] blim;
    logic [12:0] bstv, smin;
    logic [11:0] eff;
    int n_errors = 0;
    int total_checks = 0;
    int n_int = 0;
    int i0, m_limit_pin, m_pin;
    logic [3:0] rst_a [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hF};
    logic [15:0] rst_v [8] = '{16'h0129, 16'h01F4, 16'h1194, 16'h01F4, 16'h1388, 16'h0000, 16'h0DAC, 16'h0000};
    ipc_power_path #(.RETRY_CYC(30), .BIAS_CYC(20), .BOOST_CYC(10), .OPT_TICK_CYC(4)) i_ipc_power_path (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pins_in(pins), .limit_pin_ma_in(pin_ma),
        .vbus_mv_in(vbus_mv), .bias_en_out(bias), .conv_en_out(conv), .battery_switch_out(bsw),
        .boost_en_out(boost), .boost_frequency_select_out(bfreq), .boost_current_limit_out(blim),
        .boost_voltage_out(bstv), .min_system_voltage_out(smin), .input_voltage_limit_out(vlim),
        .eff_limit_pin_out(eff), .charge_reduce_out(reduce), .power_good_pin_b_out(pg_b), .host_int_b_out(int_b));
    ipc_supply_model i_ipc_supply_model (.sys_clk_in(sys_clk_in), .plug_in(plug), .slow_in(slow),
        .pass_in(pass), .psel_in(psel), .misc_in(misc), .pins_out(pins), .vbus_mv_out(vbus_mv));
    initial forever #4 sys_clk_in = !sys_clk_in;
    always @(negedge sys_clk_in) begin
        if (int_b === 1'b0) n_int++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        cyc(20000);
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(78520));
        cyc(8);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_reg(rst_a[i]);
            chk(d, rst_v[i]);
        end
        chk(16'(bstv), 16'h1388);
        chk(16'(smin), 16'h0DAC);
        note("reset");
        i0 = n_int;
        plug <= 1'b1;
        cyc(60);
        rd_reg(4'h7);
        chk(d & 16'h0027, 16'h0000);
        chk(16'(conv), 16'h0000);
        pass <= 1'b1;
        for (int i = 0; i < 300 && conv !== 1'b1; i++) @(posedge sys_clk_in);
        cyc(4);
        chk(16'(n_int - i0), 16'h0003);
        rd_reg(4'h7);
        chk(d & 16'h1077, 16'h1071);
        rd_reg(4'h1);
        chk(d, 16'h01F4);
        chk(16'(pg_b), 16'h0000);
        chk(16'(vlim), 16'h157C);
        chk(16'(eff), 16'h00C8);
        chk(16'(bsw), 16'h0001);
        note("power up");
        wr_reg(4'h0, 16'h0121);
        misc.sys_above_2v2 <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            m_limit_pin = $urandom_range(3250, 100);
            m_pin = $urandom_range(3500, 100);
            pin_ma <= 12'(m_pin);
            wr_reg(4'h1, 16'(m_limit_pin));
            cyc(6);
            chk(16'(eff), 16'(m_limit_pin < m_pin ? m_limit_pin : m_pin));
        end
        wr_reg(4'h0, 16'h0101);
        cyc(4);
        chk(16'(eff), 16'(m_limit_pin));
        note("limits");
        psel <= 1'b0;
        cyc(6);
        i0 = n_int;
        wr_reg(4'h0, 16'h0123);
        cyc(8);
        chk(16'(n_int - i0), 16'h0002);
        rd_reg(4'h0);
        chk(d, 16'h0121);
        rd_reg(4'h1);
        chk(d, 16'h0CB2);
        rd_reg(4'h7);
        chk(d & 16'h0007, 16'h0002);
        note("force detect");
        wr_reg(4'h2, 16'h1B58);
        rd_reg(4'h2);
        chk(d, 16'h157C);
        wr_reg(4'h0, 16'h0125);
        wr_reg(4'h2, 16'h1B58);
        rd_reg(4'h2);
        chk(d, 16'h1B58);
        chk(16'(vlim), 16'h1B58);
        note("voltage limit");
        misc.in_cur_over <= 1'b1;
        misc.min_system_voltage_field_reg <= 1'b1;
        cyc(6);
        chk(16'(reduce), 16'h0001);
        rd_reg(4'h7);
        chk(d & 16'h0380, 16'h0300);
        misc <= 16'h002A;
        cyc(6);
        rd_reg(4'h7);
        chk(d & 16'h0180, 16'h0080);
        misc.in_volt_under <= 1'b0;
        cyc(6);
        chk(16'(reduce), 16'h0000);
        note("dpm");
        wr_reg(4'h0, 16'h0025);
        cyc(6);
        chk(16'(bsw), 16'h0000);
        misc.sys_below_bat <= 1'b1;
        cyc(6);
        chk(16'(bsw), 16'h0001);
        misc.bat_above_depl <= 1'b0;
        cyc(6);
        chk(16'(bsw), 16'h0000);
        note("battery switch");
        wr_reg(4'h0, 16'h0024);
        wr_reg(4'h1, 16'h03E8);
        plug <= 1'b0;
        slow <= 1'b0;
        cyc(10);
        plug <= 1'b1;
        cyc(80);
        rd_reg(4'h1);
        chk(d, 16'h03E8);
        chk(16'(pg_b), 16'h0001);
        note("auto off");
        plug <= 1'b0;
        misc <= 16'h03C8;
        wr_reg(4'h5, 16'h0005);
        wr_reg(4'h0, 16'h0060);
        wr_reg(4'h0, 16'h00E0);
        rd_reg(4'h0);
        chk(d, 16'h0060);
        chk(16'(blim), 16'h0005);
        cyc(30);
        chk(16'(boost), 16'h0001);
        rd_reg(4'h7);
        chk(d & 16'h0807, 16'h0807);
        misc.bat_above_otg <= 1'b0;
        cyc(8);
        chk(16'(boost), 16'h0000);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h0, 16'h0080);
        cyc(2);
        chk(16'(bfreq), 16'h0001);
        note("boost");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
